/* inc/adc_cfg_pkg.sv */
// Package for the converter serial configuration bank: addresses, fields, reset values, patterns.
// Assumes a 10 MHz system clock and register accesses already decoded from the serial command frames.
package adc_cfg_pkg;
  // Register addresses and the low-power key
  localparam logic [8:0] ADDR_LOW_POWER = 9'h010;
  localparam logic [8:0] ADDR_KEY = 9'h011;
  localparam logic [8:0] ADDR_WR_PROTO = 9'h014;
  localparam logic [8:0] ADDR_RD_PROTO = 9'h018;
  localparam logic [8:0] ADDR_WORD_FMT = 9'h01c;
  localparam logic [7:0] KEY_VALUE = 8'h69;
  // Reset values
  localparam logic [7:0] RST_LOW_POWER = 8'h00;
  localparam logic [7:0] RST_WR_PROTO = 8'h00;
  localparam logic [7:0] RST_RD_PROTO = 8'h00;
  localparam logic [7:0] RST_WORD_FMT = 8'h00;
  // Writable bit masks; all other bits read as zero
  localparam logic [7:0] MASK_LOW_POWER = 8'h03;
  localparam logic [7:0] MASK_WR_PROTO = 8'h03;
  localparam logic [7:0] MASK_RD_PROTO = 8'hdf;
  localparam logic [7:0] MASK_WORD_FMT = 8'h3f;
  // Field positions
  localparam int LP_SLEEP_BIT = 1;
  localparam int LP_DOWN_BIT = 0;
  localparam int RP_CLK_SRC_LSB = 6;
  localparam int RP_DDR_BIT = 4;
  localparam int RP_LANE_LSB = 2;
  localparam int RP_PROTO_LSB = 0;
  localparam int WF_SPAN_LSB = 4;
  localparam int WF_PAR_BIT = 3;
  localparam int WF_PAT_LSB = 0;
  // Output protocol codes and test patterns
  localparam logic [1:0] PROTO_LEGACY = 2'h0;
  localparam logic [1:0] PROTO_SRC_SYNC = 2'h3;
  localparam logic [15:0] PAT_ZEROS = 16'h0000;
  localparam logic [15:0] PAT_ONES = 16'hffff;
  localparam logic [15:0] PAT_ALT_ONE = 16'h5555;
  localparam logic [15:0] PAT_ALT_TWO = 16'h3333;
  localparam int WORD_BITS = 20;

  // Decoded configuration handed to the rest of the converter
  typedef struct packed {
    logic light_sleep_enable;
    logic full_power_down;
    logic cpol;
    logic cpha;
    logic [1:0] source_sync_clock_source;
    logic ddr;
    logic [1:0] output_lane_count;
    logic [1:0] output_protocol_select;
  } cfg_t;

  typedef enum logic {FRAME_IDLE, FRAME_ACTIVE} frame_state_t;
endpackage

/* logic/adc_serial_cfg.sv */
// Configuration register bank and output word shifter of the converter serial port.
// Assumes register accesses arrive decoded (address, data, strobes) and all pins are synchronous to clk.
`timescale 1ns/1ps
module adc_serial_cfg (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Decoded register access
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [8:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  // Conversion result
  input wire logic conv_valid,
  input wire logic [15:0] conv_data,
  // Serial link
  input wire logic cs_n,
  input wire logic sclk,
  output logic [3:0] lane_out,
  output logic [3:0] lane_oe,
  // Decoded configuration and current output word
  output adc_cfg_pkg::cfg_t cfg,
  output logic [19:0] output_word
);
  logic [7:0] low_power_control;
  logic [7:0] write_protocol_select;
  logic [7:0] read_protocol_select;
  logic [7:0] output_word_format;
  logic key_armed;
  logic [15:0] result;
  logic [19:0] next_word;
  logic [19:0] shifter;
  logic sclk_q;
  logic [3:0] nib_par;
  logic full_par;
  logic part_par;
  logic [15:0] data_field;
  logic lead_edge;
  logic trail_edge;
  logic launch;
  logic [2:0] step;
  adc_cfg_pkg::frame_state_t state;

  // Key is armed only by the key write and consumed by the very next write
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      key_armed <= 1'b0;
    end else if (reg_wr) begin
      key_armed <= (reg_addr == adc_cfg_pkg::ADDR_KEY) && (reg_wdata == adc_cfg_pkg::KEY_VALUE);
    end
  end

  // Low-power register; an unkeyed write is dropped silently
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      low_power_control <= adc_cfg_pkg::RST_LOW_POWER;
    end else if (reg_wr && reg_addr == adc_cfg_pkg::ADDR_LOW_POWER && key_armed) begin
      low_power_control <= reg_wdata & adc_cfg_pkg::MASK_LOW_POWER;
    end
  end

  // Protocol and format registers; masks keep reserved bits at zero
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      write_protocol_select <= adc_cfg_pkg::RST_WR_PROTO;
      read_protocol_select <= adc_cfg_pkg::RST_RD_PROTO;
      output_word_format <= adc_cfg_pkg::RST_WORD_FMT;
    end else if (reg_wr) begin
      if (reg_addr == adc_cfg_pkg::ADDR_WR_PROTO) begin
        write_protocol_select <= reg_wdata & adc_cfg_pkg::MASK_WR_PROTO;
      end
      if (reg_addr == adc_cfg_pkg::ADDR_RD_PROTO) begin
        read_protocol_select <= reg_wdata & adc_cfg_pkg::MASK_RD_PROTO;
      end
      if (reg_addr == adc_cfg_pkg::ADDR_WORD_FMT) begin
        output_word_format <= reg_wdata & adc_cfg_pkg::MASK_WORD_FMT;
      end
    end
  end

  // Read data is registered; unmapped addresses, the key among them, read zero
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      case (reg_addr)
        adc_cfg_pkg::ADDR_LOW_POWER: reg_rdata <= low_power_control;
        adc_cfg_pkg::ADDR_WR_PROTO: reg_rdata <= write_protocol_select;
        adc_cfg_pkg::ADDR_RD_PROTO: reg_rdata <= read_protocol_select;
        adc_cfg_pkg::ADDR_WORD_FMT: reg_rdata <= output_word_format;
        default: reg_rdata <= 8'h00;
      endcase
    end
  end

  // Decoded configuration; protocols 01b and 10b are kept as written, behaving as legacy
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cfg <= '0;
    end else begin
      cfg.light_sleep_enable <= low_power_control[adc_cfg_pkg::LP_SLEEP_BIT];
      cfg.full_power_down <= low_power_control[adc_cfg_pkg::LP_DOWN_BIT];
      cfg.cpol <= write_protocol_select[1];
      cfg.cpha <= write_protocol_select[0];
      cfg.source_sync_clock_source <= read_protocol_select[adc_cfg_pkg::RP_CLK_SRC_LSB +: 2];
      cfg.ddr <= read_protocol_select[adc_cfg_pkg::RP_DDR_BIT];
      cfg.output_lane_count <= read_protocol_select[adc_cfg_pkg::RP_LANE_LSB +: 2];
      cfg.output_protocol_select <= read_protocol_select[adc_cfg_pkg::RP_PROTO_LSB +: 2];
    end
  end

  // Latest conversion result
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      result <= 16'h0000;
    end else if (conv_valid) begin
      result <= conv_data;
    end
  end

  // Data field: conversion result or a fixed test pattern
  always_comb begin
    case (output_word_format[adc_cfg_pkg::WF_PAT_LSB +: 3])
      3'h4: data_field = adc_cfg_pkg::PAT_ZEROS;
      3'h5: data_field = adc_cfg_pkg::PAT_ONES;
      3'h6: data_field = adc_cfg_pkg::PAT_ALT_ONE;
      3'h7: data_field = adc_cfg_pkg::PAT_ALT_TWO;
      default: data_field = result;
    endcase
  end

  // Parity per nibble, most significant nibble first
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_nib
      assign nib_par[gi] = ^data_field[15 - 4 * gi -: 4];
    end
  endgenerate

  // Partial parity grows with the span; full parity covers all 16 bits
  always_comb begin
    full_par = ^nib_par;
    case (output_word_format[adc_cfg_pkg::WF_SPAN_LSB +: 2])
      2'h0: part_par = nib_par[0];
      2'h1: part_par = ^nib_par[1:0];
      2'h2: part_par = ^nib_par[2:0];
      default: part_par = full_par;
    endcase
    next_word = {data_field, 4'h0};
    if (output_word_format[adc_cfg_pkg::WF_PAR_BIT]) begin
      next_word[3] = full_par;
      next_word[2] = part_par;
    end
  end

  // Word register tracks format and result every cycle
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      output_word <= '0;
    end else begin
      output_word <= next_word;
    end
  end

  // Clock edge detection on the sampled serial clock
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sclk_q <= 1'b0;
    end else begin
      sclk_q <= sclk;
    end
  end

  // Leading edge leaves the idle level, trailing edge returns to it
  always_comb begin
    lead_edge = (sclk != sclk_q) && (sclk_q == cfg.cpol);
    trail_edge = (sclk != sclk_q) && (sclk_q != cfg.cpol);
    if (cfg.output_protocol_select == adc_cfg_pkg::PROTO_SRC_SYNC) begin
      launch = cfg.ddr ? (sclk != sclk_q) : lead_edge;
    end else begin
      launch = cfg.cpha ? lead_edge : trail_edge;
    end
    case (cfg.output_lane_count)
      2'h2: step = 3'h2;
      2'h3: step = 3'h4;
      default: step = 3'h1;
    endcase
  end

  // Frame control: load at select, shift by the lane count on each launch edge
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state <= adc_cfg_pkg::FRAME_IDLE;
      shifter <= '0;
    end else begin
      case (state)
        adc_cfg_pkg::FRAME_IDLE: begin
          if (!cs_n) begin
            state <= adc_cfg_pkg::FRAME_ACTIVE;
            shifter <= output_word;
          end
        end
        adc_cfg_pkg::FRAME_ACTIVE: begin
          if (cs_n) begin
            state <= adc_cfg_pkg::FRAME_IDLE;
          end else if (launch) begin
            shifter <= shifter << step;
          end
        end
        default: state <= adc_cfg_pkg::FRAME_IDLE;
      endcase
    end
  end

  // Lane i carries bit 19-i of the shifter, so lane 0 always holds the most significant bit
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      lane_out <= 4'h0;
    end else if (state == adc_cfg_pkg::FRAME_IDLE) begin
      lane_out <= {output_word[16], output_word[17], output_word[18], output_word[19]};
    end else begin
      lane_out <= {shifter[16], shifter[17], shifter[18], shifter[19]};
    end
  end

  // Drivers only while selected, so devices in a star may share the lines
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      lane_oe <= 4'h0;
    end else if (cs_n) begin
      lane_oe <= 4'h0;
    end else begin
      case (cfg.output_lane_count)
        2'h2: lane_oe <= 4'h3;
        2'h3: lane_oe <= 4'hf;
        default: lane_oe <= 4'h1;
      endcase
    end
  end

  // Checks
  AST_KEY_WRITE: assert property (@(posedge clk) disable iff (rst)
    reg_wr && reg_addr == adc_cfg_pkg::ADDR_LOW_POWER && key_armed |=> low_power_control == ($past(reg_wdata) & 8'h03))
    else $error("keyed low-power write not taken");
  AST_UNKEYED: assert property (@(posedge clk) disable iff (rst)
    reg_wr && reg_addr == adc_cfg_pkg::ADDR_LOW_POWER && !key_armed |=> $stable(low_power_control))
    else $error("unkeyed low-power write changed register");
  AST_SLEEP: assert property (@(posedge clk) disable iff (rst)
    ##1 cfg.light_sleep_enable == $past(low_power_control[1]))
    else $error("light sleep does not follow register");
  AST_DOWN: assert property (@(posedge clk) disable iff (rst)
    ##1 cfg.full_power_down == $past(low_power_control[0]))
    else $error("power down does not follow register");
  AST_RSVD: assert property (@(posedge clk) disable iff (rst)
    low_power_control[7:2] == 6'h00 && write_protocol_select[7:2] == 6'h00)
    else $error("reserved bits set");
  AST_BIT5: assert property (@(posedge clk) disable iff (rst)
    reg_rd && reg_addr == adc_cfg_pkg::ADDR_RD_PROTO |=> !reg_rdata[5])
    else $error("read protocol bit 5 reads one");
  AST_FMT_TOP: assert property (@(posedge clk) disable iff (rst)
    reg_rd && reg_addr == adc_cfg_pkg::ADDR_WORD_FMT |=> reg_rdata[7:6] == 2'h0)
    else $error("format bits 7:6 read nonzero");
  AST_PARITY: assert property (@(posedge clk) disable iff (rst)
    ##1 ($past(output_word_format[3]) ? (output_word[3] == ^output_word[19:4]) : (output_word[3:2] == 2'h0)))
    else $error("parity bits wrong");
  AST_PATTERN: assert property (@(posedge clk) disable iff (rst)
    output_word_format[2:0] == 3'h6 ##1 output_word_format[2:0] == 3'h6 |-> output_word[19:4] == 16'h5555)
    else $error("test pattern wrong");
  AST_FLOAT: assert property (@(posedge clk) disable iff (rst)
    cs_n |=> lane_oe == 4'h0)
    else $error("lanes driven while deselected");
  AST_QUAD: assert property (@(posedge clk) disable iff (rst)
    !cs_n && cfg.output_lane_count == 2'h3 |=> lane_oe == 4'hf)
    else $error("quad lanes not enabled");
  COV_KEYED: cover property (@(posedge clk) key_armed && reg_wr && reg_addr == adc_cfg_pkg::ADDR_LOW_POWER);
  COV_FRAME: cover property (@(posedge clk) state == adc_cfg_pkg::FRAME_ACTIVE && launch);
  COV_SRC_DDR: cover property (@(posedge clk) cfg.output_protocol_select == 2'h3 && cfg.ddr && launch);
endmodule // adc_serial_cfg

/* tb/spi_host_model.sv */
// Host controller model: drives one chip select and the shared serial clock, captures the output lanes.
// Assumes the bench raises start after a falling clk edge and the device reads with polarity 0, phase 0.
`timescale 1ns/1ps
module spi_host_model (
  // Clock and control from the bench
  input wire logic clk,
  input wire logic start,
  input wire logic [2:0] lanes,
  // Serial link to the device
  output logic cs_n,
  output logic sclk,
  input wire logic [3:0] lane_out,
  input wire logic [3:0] lane_oe,
  // Captured word
  output logic [19:0] captured,
  output logic done
);
  logic [3:0] last;
  logic [3:0] seen;
  int rises;

  // Idle link: deselected, clock parked at its low level
  initial begin
    cs_n = 1'b1;
    sclk = 1'b0;
    captured = 20'h00000;
    done = 1'b0;
    last = 4'h0;
    seen = 4'h0;
  end

  // One frame: capture on each rising clock, the falling edges launch the next bits
  always @(posedge start) begin
    rises = 20 / lanes;
    done = 1'b0;
    @(negedge clk);
    cs_n = 1'b0; // Only this device is selected on the shared lines
    repeat (4) @(negedge clk);
    for (int k = 0; k < rises; k++) begin
      // A lane left floating shows the inverse of its last level, so it can never pass by luck
      for (int i = 0; i < 4; i++) begin
        seen[i] = lane_oe[i] ? lane_out[i] : ~last[i];
      end
      last = seen;
      for (int i = 0; i < lanes; i++) begin
        captured = {captured[18:0], seen[i]};
      end
      sclk = 1'b1;
      repeat (4) @(negedge clk);
      sclk = 1'b0;
      repeat (4) @(negedge clk);
    end
    cs_n = 1'b1;
    done = 1'b1;
  end
endmodule // spi_host_model

/* tb/test_adc_serial_config_registers.sv */
// Self-checking bench for the converter configuration bank and its output word shifter.
// Assumes decoded register strobes and a host model that runs frames in polarity 0, phase 0.
`timescale 1ns/1ps
module test_adc_serial_config_registers;
  typedef struct packed {logic [8:0] a; logic [7:0] w; logic [7:0] r; logic [10:0] c;} row_t;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [8:0] reg_addr = 9'h000;
  logic [7:0] reg_wdata = 8'h00;
  logic [7:0] reg_rdata;
  logic conv_valid = 1'b0;
  logic [15:0] conv_data = 16'h0000;
  logic cs_n;
  logic sclk;
  logic start = 1'b0;
  logic done;
  logic [2:0] lanes = 3'h1;
  logic [3:0] lane_out;
  logic [3:0] lane_oe;
  adc_cfg_pkg::cfg_t cfg;
  logic [19:0] output_word;
  logic [19:0] captured;
  int errors = 0;
  int n_checks = 0;
  int cyc = 0;
  logic [7:0] prev_rd;
  // Address, write data, read-back, decoded config; output protocol is only ever 00b or 11b
  // Read-protocol bit 5 is always written as zero
  row_t rows [10] = '{'{9'h014, 8'hff, 8'h03, 11'h180}, '{9'h014, 8'h02, 8'h02, 11'h100},
    '{9'h018, 8'hdf, 8'hdf, 11'h17f}, '{9'h018, 8'h5b, 8'h5b, 11'h13b}, '{9'h014, 8'h01, 8'h01, 11'h0bb},
    '{9'h014, 8'h00, 8'h00, 11'h03b}, '{9'h018, 8'h9f, 8'h9f, 11'h05f}, '{9'h018, 8'h07, 8'h07, 11'h007},
    '{9'h01c, 8'hff, 8'h3f, 11'h007}, '{9'h01c, 8'h00, 8'h00, 11'h007}};

  always #50 clk = ~clk;

  adc_serial_cfg adc_serial_cfg_i (.clk(clk), .rst(rst), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .conv_valid(conv_valid), .conv_data(conv_data), .cs_n(cs_n),
    .sclk(sclk), .lane_out(lane_out), .lane_oe(lane_oe), .cfg(cfg), .output_word(output_word));
  spi_host_model spi_host_model_i (.clk(clk), .start(start), .lanes(lanes), .cs_n(cs_n), .sclk(sclk),
    .lane_out(lane_out), .lane_oe(lane_oe), .captured(captured), .done(done));

  task automatic give_verdict();
    if (errors == 0 && n_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  // Comparisons per kind of result; narrower kinds widen into the word compare
  task automatic cmp_word(input logic [19:0] got, input logic [19:0] exp);
    n_checks++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic cmp_reg(input logic [7:0] got, input logic [7:0] exp);
    cmp_word({12'h000, got}, {12'h000, exp});
  endtask
  task automatic cmp_cfg(input logic [10:0] got, input logic [10:0] exp);
    cmp_word({9'h000, got}, {9'h000, exp});
  endtask

  // Register strobes are one-cycle pulses with an idle cycle between accesses
  task automatic wr(input logic [8:0] a, input logic [7:0] d);
    @(negedge clk);
    reg_wr = 1'b1;
    reg_addr = a;
    reg_wdata = d;
    @(negedge clk);
    reg_wr = 1'b0;
  endtask
  task automatic chk(input logic [8:0] a, input logic [7:0] exp);
    @(negedge clk);
    reg_rd = 1'b1;
    reg_addr = a;
    @(negedge clk);
    reg_rd = 1'b0;
    @(negedge clk);
    cmp_reg(reg_rdata, exp);
  endtask

  // Expected word; bits 1:0 are outside this block's rules and are masked by the callers
  function automatic logic [19:0] exp_word(input logic [15:0] c, input logic [5:0] f);
    logic [15:0] d;
    case (f[2:0])
      3'h4: d = 16'h0000;
      3'h5: d = 16'hffff;
      3'h6: d = 16'h5555;
      3'h7: d = 16'h3333;
      default: d = c;
    endcase
    return {d, f[3] & ^d, f[3] & ^(d >> (12 - 4 * f[5:4])), 2'b00};
  endfunction

  // One host frame on nl lanes, checking which lanes drive mid-frame and the bits received
  task automatic frame(input logic [2:0] nl, input logic [3:0] oe_exp);
    @(negedge clk);
    lanes = nl;
    start = 1'b1;
    repeat (3) @(negedge clk);
    cmp_reg({4'h0, lane_oe}, {4'h0, oe_exp});
    for (int k = 0; k < 400 && done !== 1'b1; k++) @(negedge clk);
    start = 1'b0;
    cmp_word({captured[19:2], 2'b00}, 20'h9c350);
    repeat (2) @(negedge clk);
    cmp_reg({4'h0, lane_oe}, 8'h00);
  endtask

  // Hang guard: the whole sequence needs well under 3000 cycles
  always @(posedge clk) begin
    cyc++;
    if (cyc == 5000) begin
      errors++;
      give_verdict();
    end
  end

  initial begin
    repeat (12) @(negedge clk);
    rst = 1'b0;
    foreach (rows[i]) begin
      // Before the write a register still holds its reset value or the value of the last earlier row for its address
      prev_rd = 8'h00;
      for (int j = 0; j < i; j++) begin
        if (rows[j].a == rows[i].a) prev_rd = rows[j].r;
      end
      chk(rows[i].a, prev_rd);
      wr(rows[i].a, rows[i].w);
      chk(rows[i].a, rows[i].r);
      cmp_cfg(cfg, rows[i].c);
      if (i == 0) chk(9'h010, 8'h00);
    end
    // Keyed low-power register: unkeyed, keyed, key spent elsewhere, wrong key, key kept across a read
    wr(9'h010, 8'h03);
    chk(9'h010, 8'h00);
    wr(9'h011, 8'h69);
    wr(9'h010, 8'hff);
    chk(9'h010, 8'h03);
    cmp_cfg(cfg, 11'h607);
    wr(9'h011, 8'h69);
    wr(9'h014, 8'h01);
    wr(9'h010, 8'h00);
    chk(9'h010, 8'h03);
    wr(9'h011, 8'h68);
    wr(9'h010, 8'h00);
    chk(9'h010, 8'h03);
    wr(9'h011, 8'h69);
    chk(9'h011, 8'h00);
    wr(9'h010, 8'h02);
    chk(9'h010, 8'h02);
    cmp_cfg(cfg, 11'h487);
    chk(9'h1fc, 8'h00);
    // Every format setting against a fixed conversion result
    @(negedge clk);
    conv_data = 16'h9c35;
    conv_valid = 1'b1;
    @(negedge clk);
    conv_valid = 1'b0;
    for (int f = 0; f < 64; f++) begin
      wr(9'h01c, 8'(f));
      repeat (2) @(negedge clk);
      cmp_word({output_word[19:2], 2'b00}, exp_word(16'h9c35, 6'(f)));
    end
    // Frames on one and on four lanes, following the input protocol
    wr(9'h01c, 8'h00);
    wr(9'h014, 8'h00);
    wr(9'h018, 8'h00);
    cmp_reg({4'h0, lane_oe}, 8'h00);
    frame(3'h1, 4'h1);
    wr(9'h018, 8'h0c);
    frame(3'h4, 4'hf);
    // Source-synchronous, single rate, two lanes: launch moves to the leading edge
    wr(9'h018, 8'h0b);
    frame(3'h2, 4'h3);
    // Reset again in mid-run
    @(negedge clk);
    rst = 1'b1;
    @(negedge clk);
    rst = 1'b0;
    chk(9'h010, 8'h00);
    cmp_cfg(cfg, 11'h000);
    give_verdict();
  end
endmodule // test_adc_serial_config_registers
